/* design/trlc_pkg.sv */
package trlc_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 40000000;
    // wobble time resolution, one tick = 0.1 s
    localparam int unsigned TICK_TIME_MS    = 100;
    localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_TIME_MS;

    // ****************************************
    // scaling
    // ****************************************
    // percentages are in 0.1 % steps
    localparam logic [9:0]  PCT_FULL          = 10'h3E8;
    localparam logic [9:0]  KICK_PCT_MAX      = 10'h1F4;
    // one pulse in 0.1 pulse units, matches the pulses-per-metre scale
    localparam logic [16:0] PULSE_TENTHS      = 17'h0000A;
    localparam logic [15:0] LENGTH_MAX        = 16'hFFFF;
    localparam logic [15:0] WOBBLE_PERIOD_MAX = 16'h7530;
    localparam logic        SWING_REF_CENTRE  = 1'b0;
    localparam logic        SWING_REF_MAX     = 1'b1;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [15:0] centreFrequencySource;
        logic [15:0] maximumFrequencySetting;
        logic [15:0] minimumFrequency;
    } trlc_freq_s;

    typedef struct packed {
        logic        swingReferenceSelect;
        logic [9:0]  swingAmplitudePct;
        logic [9:0]  kickAmplitudePct;
        logic [15:0] wobblePeriod;
        logic [9:0]  riseFraction;
    } trlc_swing_cfg_s;

    typedef struct packed {
        logic [15:0] targetLength;
        logic [15:0] pulsesPerMetre;
        logic [15:0] finalCountTarget;
        logic [15:0] intermediateCountTarget;
    } trlc_meter_cfg_s;

    typedef enum logic [1:0] {
        RAMP_IDLE = 2'b00,
        RAMP_RISE = 2'b01,
        RAMP_FALL = 2'b10
    } trlc_ramp_e;

    typedef struct packed {
        logic meta;
        logic stable;
        logic prev;
        logic rise;
    } trlc_sync_s;

    typedef struct packed {
        trlc_ramp_e  mode;
        logic [31:0] tickCnt;
        logic [15:0] phase;
    } trlc_ramp_s;

    typedef struct packed {
        logic [15:0] outFrequency;
        logic        traverseActive;
        logic [15:0] measuredLength;
        logic [16:0] pulseAcc;
        logic        lengthArrived;
        logic [15:0] countValue;
        logic        finalCountReached;
        logic        intermediateCountReached;
    } trlc_top_s;

endpackage

/* design/trlc_pulse_sync.sv */
`timescale 1ns/1ps
module trlc_pulse_sync
    import trlc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);

    trlc_sync_s st;
    trlc_sync_s next_st;

    // meta feeds stable only; the edge is taken one stage later
    always_comb
    begin
        next_st        = st;
        next_st.meta   = pin;
        next_st.stable = st.meta;
        next_st.prev   = st.stable;
        next_st.rise   = st.stable & ~st.prev;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign level = st.prev;
    assign rise  = st.rise;

endmodule

/* design/trlc_ramp.sv */
`timescale 1ns/1ps
module trlc_ramp
    import trlc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        run,
    input  wire logic [15:0] wobblePeriod,
    input  wire logic [9:0]  riseFraction,
    output logic             rising,
    output logic [15:0]      phase,
    output logic [15:0]      rampLen
);

    trlc_ramp_s  st;
    trlc_ramp_s  next_st;
    logic [15:0] period;
    logic [9:0]  frac;
    logic [25:0] riseProd;
    logic [15:0] riseLen;
    logic [15:0] fallLen;
    logic        tickDone;
    logic        turn;

    always_comb
    begin
        period   = (wobblePeriod > WOBBLE_PERIOD_MAX) ? WOBBLE_PERIOD_MAX : wobblePeriod;
        frac     = (riseFraction > PCT_FULL) ? PCT_FULL : riseFraction;
        riseProd = period * frac;
        riseLen  = 16'(riseProd / 26'(PCT_FULL));
        fallLen  = period - riseLen;
        rampLen  = (st.mode == RAMP_FALL) ? fallLen : riseLen;
        rising   = (st.mode != RAMP_FALL);
        phase    = st.phase;
        tickDone = (st.tickCnt == 32'(TICK_CYCLES - 1));
        // a zero-length ramp still lasts one tick
        turn     = ({1'b0, st.phase} + 17'h00001) >= {1'b0, rampLen};
    end

    always_comb
    begin
        next_st = st;
        if (!run)
        begin
            next_st = '0;
        end
        else
        begin
            next_st.tickCnt = tickDone ? '0 : st.tickCnt + 32'h00000001;
            case (st.mode)
                RAMP_IDLE:
                begin
                    next_st.mode    = RAMP_RISE;
                    next_st.phase   = '0;
                    next_st.tickCnt = '0;
                end
                RAMP_RISE:
                begin
                    if (tickDone)
                    begin
                        if (turn)
                        begin
                            next_st.mode  = RAMP_FALL;
                            next_st.phase = '0;
                        end
                        else
                            next_st.phase = st.phase + 16'h0001;
                    end
                end
                RAMP_FALL:
                begin
                    if (tickDone)
                    begin
                        if (turn)
                        begin
                            next_st.mode  = RAMP_RISE;
                            next_st.phase = '0;
                        end
                        else
                            next_st.phase = st.phase + 16'h0001;
                    end
                end
                default:
                    next_st.mode = RAMP_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

endmodule

/* design/trlc_top.sv */
// Contract
// - A swing amplitude of zero turns traverse off, so the frequency does not swing.
// - Swing reference 0 follows the centre frequency, 1 follows the maximum frequency.
// - The swing span is the reference frequency times the swing amplitude percentage.
// - The kick is the span times the kick percentage, limited to 0 to 50 percent.
// - The traverse output never exceeds the maximum and drops below the minimum frequency only when the two limits are set crossed.
// - The wobble period, up to 3000 s and 10 s by default, is one full swing cycle.
// - The rise lasts period times rise fraction and the fall the rest of the period.
// - Measured length is the length pulse count divided by pulses per metre.
// - Length arrival is flagged once the measured length exceeds the target length.
// - An active length reset input clears the measured length.
// - At the final count target the final flag rises and counting stops.
// - At the intermediate count target its flag rises and counting goes on.
`timescale 1ns/1ps
module trlc_top
    import trlc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            traverseRun,
    input  wire trlc_freq_s      freqCfg,
    input  wire trlc_swing_cfg_s swingCfg,
    input  wire trlc_meter_cfg_s meterCfg,
    input  wire logic            lengthCountPin,
    input  wire logic            lengthResetPin,
    input  wire logic            counterInputPin,
    input  wire logic            counterResetPin,
    output logic [15:0]          outFrequency,
    output logic                 traverseActive,
    output logic [15:0]          measuredLength,
    output logic                 lengthArrived,
    output logic [15:0]          countValue,
    output logic                 finalCountReached,
    output logic                 intermediateCountReached
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] pctOf(input logic [15:0] base, input logic [9:0] pct);
        logic [25:0] prod;
        prod  = base * pct;
        pctOf = 16'(prod / 26'(PCT_FULL));
    endfunction

    // share of a ramp travelled after t of len ticks
    function automatic logic [16:0] lerp(input logic [16:0] range, input logic [15:0] t,
                                         input logic [15:0] len);
        logic [32:0] prod;
        prod = range * t;
        if (len == 16'h0000)
            lerp = '0;
        else
            lerp = 17'(prod / 33'(len));
    endfunction

    // ****************************************
    // input synchronisers
    // ****************************************
    logic lenPulse;
    logic lenResetLvl;
    logic cntPulse;
    logic cntResetLvl;

    // the outside routes pulses here; the pins are asynchronous to ref_clk
    trlc_pulse_sync u_len_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (lengthCountPin),
        .level   (),
        .rise    (lenPulse)
    );

    trlc_pulse_sync u_len_rst_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (lengthResetPin),
        .level   (lenResetLvl),
        .rise    ()
    );

    trlc_pulse_sync u_cnt_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (counterInputPin),
        .level   (),
        .rise    (cntPulse)
    );

    trlc_pulse_sync u_cnt_rst_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin     (counterResetPin),
        .level   (cntResetLvl),
        .rise    ()
    );

    // ****************************************
    // swing track
    // ****************************************
    logic        swingOn;
    logic        rampRising;
    logic [15:0] rampPhase;
    logic [15:0] rampLen;

    assign swingOn = traverseRun && (swingCfg.swingAmplitudePct != 10'h000);

    trlc_ramp #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_ramp (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .run          (swingOn),
        .wobblePeriod (swingCfg.wobblePeriod),
        .riseFraction (swingCfg.riseFraction),
        .rising       (rampRising),
        .phase        (rampPhase),
        .rampLen      (rampLen)
    );

    logic [9:0]         ampPct;
    logic [9:0]         kickPct;
    logic [15:0]        swingBase;
    logic [15:0]        swingSpan;
    logic [15:0]        kickFreq;
    logic [15:0]        rampDiv;
    logic [16:0]        travel;
    logic [16:0]        stepFreq;
    logic signed [18:0] spanS;
    logic signed [18:0] kickS;
    logic signed [18:0] stepS;
    logic signed [18:0] offset;
    logic signed [18:0] freqRaw;
    logic signed [18:0] freqLow;
    logic signed [18:0] freqClamped;

    always_comb
    begin
        ampPct    = (swingCfg.swingAmplitudePct > PCT_FULL) ? PCT_FULL
                                                            : swingCfg.swingAmplitudePct;
        kickPct   = (swingCfg.kickAmplitudePct > KICK_PCT_MAX) ? KICK_PCT_MAX
                                                               : swingCfg.kickAmplitudePct;
        swingBase = (swingCfg.swingReferenceSelect == SWING_REF_MAX)
                  ? freqCfg.maximumFrequencySetting
                  : freqCfg.centreFrequencySource;
        swingSpan = pctOf(swingBase, ampPct);
        kickFreq  = pctOf(swingSpan, kickPct);
        // rise goes from -span+kick to +span, fall from +span-kick to -span
        travel    = {swingSpan, 1'b0} - {1'b0, kickFreq};
        // the last tick lands on the end point, so each turn steps by the whole kick
        rampDiv   = (rampLen > 16'h0001) ? rampLen - 16'h0001 : 16'h0000;
        stepFreq  = lerp(travel, rampPhase, rampDiv);
        spanS     = $signed({3'b000, swingSpan});
        kickS     = $signed({3'b000, kickFreq});
        stepS     = $signed({2'b00, stepFreq});
        if (rampRising)
            offset = kickS - spanS + stepS;
        else
            offset = spanS - kickS - stepS;
        if (swingOn)
            freqRaw = $signed({3'b000, freqCfg.centreFrequencySource}) + offset;
        else
            freqRaw = $signed({3'b000, freqCfg.centreFrequencySource});
        // the maximum wins if the limits are set crossed
        freqLow     = (freqRaw < $signed({3'b000, freqCfg.minimumFrequency}))
                    ? $signed({3'b000, freqCfg.minimumFrequency}) : freqRaw;
        freqClamped = (freqLow > $signed({3'b000, freqCfg.maximumFrequencySetting}))
                    ? $signed({3'b000, freqCfg.maximumFrequencySetting}) : freqLow;
    end

    // ****************************************
    // state
    // ****************************************
    trlc_top_s   st;
    trlc_top_s   next_st;
    logic [16:0] accSum;
    logic [15:0] ppm;

    always_comb
    begin
        next_st                = st;
        next_st.outFrequency   = freqClamped[15:0];
        next_st.traverseActive = swingOn;

        // length meter works in tenths of a pulse, a zero factor acts as 0.1
        ppm    = (meterCfg.pulsesPerMetre == 16'h0000) ? 16'h0001 : meterCfg.pulsesPerMetre;
        accSum = st.pulseAcc + (lenPulse ? PULSE_TENTHS : 17'h00000);
        if (lenResetLvl)
        begin
            // a pulse in the clearing cycle is still kept
            next_st.measuredLength = '0;
            next_st.pulseAcc       = lenPulse ? PULSE_TENTHS : 17'h00000;
        end
        else if (accSum >= {1'b0, ppm})
        begin
            next_st.pulseAcc = accSum - {1'b0, ppm};
            if (st.measuredLength != LENGTH_MAX)
                next_st.measuredLength = st.measuredLength + 16'h0001;
        end
        else
            next_st.pulseAcc = accSum;
        next_st.lengthArrived = next_st.measuredLength > meterCfg.targetLength;

        if (cntResetLvl)
            next_st.countValue = '0;
        else if (cntPulse && (st.countValue < meterCfg.finalCountTarget))
            next_st.countValue = st.countValue + 16'h0001;
        next_st.finalCountReached =
            next_st.countValue >= meterCfg.finalCountTarget;
        // with the order the far side keeps, this flag rises no later than the final one
        next_st.intermediateCountReached =
            next_st.countValue >= meterCfg.intermediateCountTarget;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign outFrequency             = st.outFrequency;
    assign traverseActive           = st.traverseActive;
    assign measuredLength           = st.measuredLength;
    assign lengthArrived            = st.lengthArrived;
    assign countValue               = st.countValue;
    assign finalCountReached        = st.finalCountReached;
    assign intermediateCountReached = st.intermediateCountReached;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_ACTIVE_ON: assert property (
        traverseRun && (swingCfg.swingAmplitudePct != 10'h000) |=> traverseActive)
        else $error("traverse not active while running with amplitude");

    AST_ZERO_AMP_OFF: assert property (
        (swingCfg.swingAmplitudePct == 10'h000) |=> !traverseActive)
        else $error("traverse active with zero amplitude");

    AST_SPAN_BOUND: assert property (
        swingSpan <= swingBase)
        else $error("swing span above its reference");

    AST_KICK_LIMIT: assert property (
        kickFreq <= {1'b0, swingSpan[15:1]})
        else $error("kick above half the span");

    AST_FREQ_CLAMP: assert property (
        !$past(rst) && $stable(freqCfg)
        && (freqCfg.minimumFrequency <= freqCfg.maximumFrequencySetting)
        |-> (outFrequency <= freqCfg.maximumFrequencySetting)
            && (outFrequency >= freqCfg.minimumFrequency))
        else $error("output frequency outside limits");

    AST_LEN_STEP: assert property (
        !lenResetLvl |=> (measuredLength == $past(measuredLength))
                      || (measuredLength == $past(measuredLength) + 16'h0001))
        else $error("length moved by more than one metre");

    AST_LEN_ARRIVE: assert property (
        !$past(rst) |-> lengthArrived == (measuredLength > $past(meterCfg.targetLength)))
        else $error("length arrival flag wrong");

    AST_LEN_CLEAR: assert property (
        lenResetLvl |=> (measuredLength == 16'h0000) && !lengthArrived ##1 1'b1)
        else $error("length not cleared");

    AST_CNT_STOP: assert property (
        finalCountReached && !cntResetLvl && $stable(meterCfg.finalCountTarget)
        |=> $stable(countValue))
        else $error("counting went on past the final target");

    AST_CNT_FINAL: assert property (
        !$past(rst) |-> finalCountReached == (countValue >= $past(meterCfg.finalCountTarget)))
        else $error("final count flag wrong");

    AST_CNT_MID: assert property (
        !$past(rst)
        |-> intermediateCountReached == (countValue >= $past(meterCfg.intermediateCountTarget)))
        else $error("intermediate count flag wrong");

    AST_CNT_STEP: assert property (
        !cntResetLvl |=> (countValue == $past(countValue))
                      || (countValue == $past(countValue) + 16'h0001))
        else $error("count moved by more than one");

    AST_IDLE_CENTRE: assert property (
        !$past(rst) && !traverseActive && $stable(freqCfg)
        && (freqCfg.minimumFrequency <= freqCfg.centreFrequencySource)
        && (freqCfg.centreFrequencySource <= freqCfg.maximumFrequencySetting)
        |-> outFrequency == freqCfg.centreFrequencySource)
        else $error("output frequency moved while traverse is off");

    COV_TURN: cover property (swingOn && rampRising ##1 !rampRising);
    COV_LEN_ARRIVE: cover property (!lengthArrived ##1 lengthArrived);
    COV_MID_THEN_FINAL: cover property (intermediateCountReached && !finalCountReached
                                        ##[1:1000] finalCountReached);
    COV_CNT_HELD: cover property (finalCountReached && cntPulse);

endmodule

/* tb/trlc_pulse_model.sv */
`timescale 1ns/1ps
// ****************************************
// pulse source on a multifunction input
// ****************************************
module trlc_pulse_model
(
    input  wire logic ref_clk,
    input  wire logic go,
    output logic      pin
);
    logic [2:0] cnt = 3'h0;

    // two cycles high, then at least two low, so pulses are never merged
    always @(posedge ref_clk)
    begin
        if (go)
            cnt <= 3'h4;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
    end

    assign pin = (cnt > 3'h2);
endmodule

/* tb/trlc_top_tb_top.sv */
`timescale 1ns/1ps
module trlc_top_tb_top
    import trlc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic traverseRun = 1'b0;
    trlc_freq_s freqCfg = {16'h03E8, 16'h07D0, 16'h0000};
    trlc_swing_cfg_s swingCfg = {1'b0, 10'h000, 10'h0C8, 16'h000A, 10'h12C};
    trlc_meter_cfg_s meterCfg = {16'h0002, 16'h0014, 16'h0003, 16'h0002};
    logic lenGo = 1'b0;
    logic cntGo = 1'b0;
    logic lengthCountPin;
    logic counterInputPin;
    logic lengthResetPin = 1'b0;
    logic counterResetPin = 1'b0;
    logic [15:0] outFrequency;
    logic traverseActive;
    logic [15:0] measuredLength;
    logic lengthArrived;
    logic [15:0] countValue;
    logic finalCountReached;
    logic intermediateCountReached;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] below;
    logic [15:0] v0;

    trlc_top #(.TICK_CYCLES(4)) trlc_top_inst (
        .ref_clk(ref_clk), .rst(rst), .traverseRun(traverseRun),
        .freqCfg(freqCfg), .swingCfg(swingCfg), .meterCfg(meterCfg),
        .lengthCountPin(lengthCountPin), .lengthResetPin(lengthResetPin),
        .counterInputPin(counterInputPin), .counterResetPin(counterResetPin),
        .outFrequency(outFrequency), .traverseActive(traverseActive),
        .measuredLength(measuredLength), .lengthArrived(lengthArrived),
        .countValue(countValue), .finalCountReached(finalCountReached),
        .intermediateCountReached(intermediateCountReached));
    trlc_pulse_model trlc_pulse_model_inst (.ref_clk(ref_clk), .go(lenGo),
        .pin(lengthCountPin));
    trlc_pulse_model trlc_pulse_model_cnt_inst (.ref_clk(ref_clk), .go(cntGo),
        .pin(counterInputPin));

    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pulse(input logic onCount);
        @(posedge ref_clk);
        if (onCount) cntGo <= 1'b1; else lenGo <= 1'b1;
        @(posedge ref_clk);
        cntGo <= 1'b0;
        lenGo <= 1'b0;
        step(10);
    endtask

    // two full periods of 40 cycles, so the result does not depend on phase
    task automatic scan();
        lo = 16'hFFFF;
        hi = 16'h0000;
        below = 16'h0000;
        step(60);
        repeat (80)
        begin
            step(1);
            if (outFrequency < lo) lo = outFrequency;
            if (outFrequency > hi) hi = outFrequency;
            if (outFrequency < 16'h03E8) below = below + 16'h0001;
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // timeout far above the roughly 630 cycles the sequence needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        step(6);
        check("resetFreq", outFrequency, 16'h0000);
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        traverseRun <= 1'b1;
        step(20);
        check("activeAmp0", 16'(traverseActive), 16'h0000);
        check("freqAmp0", outFrequency, 16'h03E8);
        // span 100, kick 20, rise 3 ticks and fall 7 ticks
        @(posedge ref_clk);
        swingCfg.swingAmplitudePct <= 10'h064;
        scan();
        check("active", 16'(traverseActive), 16'h0001);
        check("lowCentre", lo, 16'h0384);
        check("highCentre", hi, 16'h044C);
        check("belowCentre", below, 16'h0028);
        v0 = outFrequency;
        step(40);
        check("period", outFrequency, v0);
        // span 200 from the maximum, kick 40
        @(posedge ref_clk);
        swingCfg.swingReferenceSelect <= 1'b1;
        scan();
        check("lowMax", lo, 16'h0320);
        check("highMax", hi, 16'h04B0);
        @(posedge ref_clk);
        swingCfg.swingReferenceSelect <= 1'b0;
        freqCfg.minimumFrequency <= 16'h0384;
        freqCfg.maximumFrequencySetting <= 16'h041A;
        scan();
        check("lowClamp", lo, 16'h0384);
        check("highClamp", hi, 16'h041A);
        // two pulses a metre at 2.0 pulses per metre
        repeat (4) pulse(1'b0);
        check("length2", measuredLength, 16'h0002);
        check("arrivedEq", 16'(lengthArrived), 16'h0000);
        repeat (2) pulse(1'b0);
        check("length3", measuredLength, 16'h0003);
        check("arrived", 16'(lengthArrived), 16'h0001);
        @(posedge ref_clk);
        lengthResetPin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        lengthResetPin <= 1'b0;
        step(2);
        check("lengthClr", measuredLength, 16'h0000);
        check("arrivedClr", 16'(lengthArrived), 16'h0000);
        pulse(1'b1);
        check("inter1", 16'(intermediateCountReached), 16'h0000);
        pulse(1'b1);
        check("inter2", 16'(intermediateCountReached), 16'h0001);
        check("final2", 16'(finalCountReached), 16'h0000);
        check("count2", countValue, 16'h0002);
        repeat (2) pulse(1'b1);
        check("final", 16'(finalCountReached), 16'h0001);
        check("countStop", countValue, 16'h0003);
        @(posedge ref_clk);
        counterResetPin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        counterResetPin <= 1'b0;
        step(2);
        check("countClr", countValue, 16'h0000);
        check("finalClr", 16'(finalCountReached), 16'h0000);
        tally_and_finish();
    end
endmodule
